// file: inc/sdrf_pkg.sv
// Shared constants and carrier types for the card response framer
package sdrf_pkg;

  // ----------------------------------------------------------------
  // Frame geometry
  // ----------------------------------------------------------------
  localparam int SHORT_LEN = 48;
  localparam int LONG_LEN = 136;
  localparam int CNT_W = 8;
  localparam logic [5:0] IDX_ALL_ONES = 6'h3F;
  localparam logic [5:0] IDX_PUB_ADDR = 6'h03;
  localparam logic [6:0] CRC_ALL_ONES = 7'h7F;
  localparam logic [6:0] CRC_POLY = 7'h09;
  localparam logic [6:0] CRC_INIT = 7'h00;
  localparam int CRC_START_BIT = 7;
  localparam int TURN_Z_BITS = 2;

  // ----------------------------------------------------------------
  // Link timing defaults, in link clock cycles
  // ----------------------------------------------------------------
  localparam int ID_DELAY_DEF = 5;
  // Two Z bits plus at least one P bit before the start bit
  localparam int CR_DELAY_DEF = 3;
  localparam int RC_GAP_DEF = 8;

  // ----------------------------------------------------------------
  // Response kinds and request carrier
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SDRF_R1,
    SDRF_R1B,
    SDRF_R2,
    SDRF_R3,
    SDRF_R6,
    SDRF_R4,
    SDRF_R5
  } sdrf_kind_e;

  typedef struct packed {
    sdrf_kind_e kind;
    logic [5:0] cmd_index;
    logic [31:0] status;
    logic [127:0] reg_long;
    logic [15:0] new_addr;
    logic busy;
  } sdrf_req_s;

  localparam int REQ_W = $bits(sdrf_req_s);

endpackage : sdrf_pkg

// file: src/sdrf_framer.sv
// Card response framer: builds and serialises responses on the command line
// ------------------------------------------------------------------
// What this block does
// - Responses go out on the command line only, MSB first.
// - Each response starts with start bit zero then direction bit zero.
// - All formats carry CRC7 except operating-conditions reply.
// - Every response ends with a single end bit of one.
// - Standard response: 48 bits, index 45:40, status 39:8, CRC 7:1.
// - Busy variant may hold data line low after the response.
// - Card may show busy on data line after each written block.
// - Long response: 136 bits, ones 133:128, register 127:1, end bit.
// - Identification and specific-data registers return in long response.
// - Operating-conditions reply: ones index, register 39:8, ones 7:1.
// - R4 and R5 formats are never generated.
// - Address reply: index 3, new address 31:16, condensed status 15:0.
// - Command line bits change on the rising host clock edge.
// - Two undriven bits after command, then driven high bits, then start.
// - Identification replies start a fixed delay after the command ends.
// - Address reply starts no sooner than minimum command-response delay.
// - After address publish, general timing applies to other commands.
// - Direction bit is one from host, zero from card.
// - Pull-up bits are driven high; Z bits are left undriven.
// ------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none

module sdrf_framer #(
  parameter int ID_DELAY = sdrf_pkg::ID_DELAY_DEF,
  parameter int CR_DELAY = sdrf_pkg::CR_DELAY_DEF,
  parameter int RC_GAP = sdrf_pkg::RC_GAP_DEF
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic link_clk_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire sdrf_pkg::sdrf_req_s req_i,
  input wire logic cmd_end_i,
  input wire logic wr_busy_i,
  output logic done_o,
  output logic addr_published_o,
  input wire logic cmd_i,
  output logic cmd_o,
  output logic cmd_oe_o,
  input wire logic dat0_i,
  output logic dat0_o,
  output logic dat0_oe_o
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // Delays must leave room for two Z bits and at least one P bit
  if (ID_DELAY < sdrf_pkg::TURN_Z_BITS + 1 || CR_DELAY < sdrf_pkg::TURN_Z_BITS + 1 ||
      ID_DELAY > 200 || CR_DELAY > 200 || RC_GAP < 1) begin : g_bad_par
    $error("sdrf_framer: delay parameters out of range");
  end

  localparam logic [7:0] ID_CNT = 8'(ID_DELAY);
  localparam logic [7:0] CR_CNT = 8'(CR_DELAY);

  // ----------------------------------------------------------------
  // Core side: request capture and toggle handshake
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {C_IDLE, C_WAIT} sdrf_core_e;
  sdrf_core_e cst_reg;
  sdrf_pkg::sdrf_req_s hold_reg;
  logic req_tgl_reg;
  logic ack_s1_reg, ack_s2_reg, ack_s3_reg;
  logic rcvr_tgl_reg;
  logic addr_pub_reg;
  logic [1:0] busy_sync_reg;
  logic addr_pub_s1_reg, addr_pub_s2_reg;

  assign req_ready_o = (cst_reg == C_IDLE);

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cst_reg <= C_IDLE;
      hold_reg <= '0;
      req_tgl_reg <= 1'b0;
    end else begin
      case (cst_reg)
        C_IDLE: begin
          if (req_valid_i) begin
            hold_reg <= req_i;
            req_tgl_reg <= ~req_tgl_reg;
            cst_reg <= C_WAIT;
          end
        end
        C_WAIT: begin
          if (ack_s2_reg != ack_s3_reg) begin
            cst_reg <= C_IDLE;
          end
        end
        default: cst_reg <= C_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
      ack_s3_reg <= 1'b0;
      done_o <= 1'b0;
      addr_pub_s1_reg <= 1'b0;
      addr_pub_s2_reg <= 1'b0;
      addr_published_o <= 1'b0;
    end else begin
      ack_s1_reg <= rcvr_tgl_reg;
      ack_s2_reg <= ack_s1_reg;
      ack_s3_reg <= ack_s2_reg;
      done_o <= (ack_s2_reg != ack_s3_reg);
      addr_pub_s1_reg <= addr_pub_reg;
      addr_pub_s2_reg <= addr_pub_s1_reg;
      addr_published_o <= addr_pub_s2_reg;
    end
  end

  // ----------------------------------------------------------------
  // Link side
  // ----------------------------------------------------------------
  // The link reset is the core reset brought across; the host clock runs
  // through reset in the bench, so the reset reaches this domain.
  logic lrst_s1_reg, lrst_reg;
  logic [1:0] req_sync_reg;
  logic req_seen_reg;
  typedef enum logic [2:0] {L_IDLE, L_ARMED, L_TURN, L_PULL, L_SEND, L_BUSY} sdrf_link_e;
  sdrf_link_e lst_reg;
  logic [135:0] frame_reg;
  logic [7:0] len_reg;
  logic [7:0] bit_reg;
  logic [7:0] wait_reg;
  logic [6:0] crc_reg;
  logic use_crc_reg;
  logic busy_reg;
  logic [1:0] cend_sync_reg;
  logic cend_d_reg;

  always_ff @(posedge link_clk_i) begin
    lrst_s1_reg <= rst_i;
    lrst_reg <= lrst_s1_reg;
    req_sync_reg <= {req_sync_reg[0], req_tgl_reg};
    cend_sync_reg <= {cend_sync_reg[0], cmd_end_i};
    busy_sync_reg <= {busy_sync_reg[0], wr_busy_i};
  end

  // Frame builder: one image per format, sent MSB first
  function automatic logic [135:0] build(input sdrf_pkg::sdrf_req_s r);
    logic [135:0] f;
    logic [15:0] cond;
    f = '0;
    cond = {r.status[23], r.status[22], r.status[19], r.status[12:0]};
    case (r.kind)
      sdrf_pkg::SDRF_R2: begin
        f = {2'b00, sdrf_pkg::IDX_ALL_ONES, r.reg_long[127:1], 1'b1};
      end
      sdrf_pkg::SDRF_R3: begin
        f[135:88] = {2'b00, sdrf_pkg::IDX_ALL_ONES, r.status, sdrf_pkg::CRC_ALL_ONES, 1'b1};
      end
      sdrf_pkg::SDRF_R6: begin
        f[135:88] = {2'b00, sdrf_pkg::IDX_PUB_ADDR, r.new_addr, cond, 8'h01};
      end
      default: begin
        f[135:88] = {2'b00, r.cmd_index, r.status, 8'h01};
      end
    endcase
    return f;
  endfunction : build

  wire logic new_req = (req_sync_reg[1] != req_seen_reg);
  wire logic cend_rise = cend_sync_reg[1] & ~cend_d_reg;
  wire logic is_unsup = (hold_reg.kind == sdrf_pkg::SDRF_R4) ||
                        (hold_reg.kind == sdrf_pkg::SDRF_R5);
  wire logic crc_fb = frame_reg[135] ^ crc_reg[6];
  // CRC field starts once all but the last 8 bits are sent
  wire logic in_crc = use_crc_reg && (bit_reg >= len_reg - 8'(sdrf_pkg::CRC_START_BIT + 1))
                      && (bit_reg < len_reg - 8'h01);
  wire logic [7:0] crc_idx = 8'(len_reg - 8'h02 - bit_reg);

  always_ff @(posedge link_clk_i) begin
    if (lrst_reg) begin
      lst_reg <= L_IDLE;
      req_seen_reg <= 1'b0;
      rcvr_tgl_reg <= 1'b0;
      frame_reg <= '0;
      len_reg <= 8'h00;
      bit_reg <= 8'h00;
      wait_reg <= 8'h00;
      crc_reg <= sdrf_pkg::CRC_INIT;
      use_crc_reg <= 1'b0;
      busy_reg <= 1'b0;
      addr_pub_reg <= 1'b0;
      cend_d_reg <= 1'b0;
    end else begin
      cend_d_reg <= cend_sync_reg[1];
      case (lst_reg)
        L_IDLE: begin
          if (new_req) begin
            req_seen_reg <= req_sync_reg[1];
            if (is_unsup) begin
              rcvr_tgl_reg <= ~rcvr_tgl_reg;
            end else begin
              frame_reg <= build(hold_reg);
              len_reg <= (hold_reg.kind == sdrf_pkg::SDRF_R2) ?
                         8'(sdrf_pkg::LONG_LEN) : 8'(sdrf_pkg::SHORT_LEN);
              // Long reply carries the register's own CRC, operating-conditions reply none
              use_crc_reg <= (hold_reg.kind != sdrf_pkg::SDRF_R3) &&
                             (hold_reg.kind != sdrf_pkg::SDRF_R2);
              busy_reg <= hold_reg.busy && (hold_reg.kind == sdrf_pkg::SDRF_R1B);
              lst_reg <= L_ARMED;
            end
          end
        end
        L_ARMED: begin
          if (cend_rise) begin
            // Fixed delay for identification replies, least delay otherwise
            wait_reg <= (hold_reg.kind == sdrf_pkg::SDRF_R2 && !addr_pub_reg) ||
                        (hold_reg.kind == sdrf_pkg::SDRF_R3) ? ID_CNT : CR_CNT;
            bit_reg <= 8'h00;
            lst_reg <= L_TURN;
          end
        end
        L_TURN: begin
          wait_reg <= wait_reg - 8'h01;
          bit_reg <= bit_reg + 8'h01;
          if (bit_reg == 8'(sdrf_pkg::TURN_Z_BITS - 1)) begin
            lst_reg <= L_PULL;
          end
        end
        L_PULL: begin
          wait_reg <= wait_reg - 8'h01;
          if (wait_reg == 8'h01) begin
            bit_reg <= 8'h00;
            crc_reg <= sdrf_pkg::CRC_INIT;
            lst_reg <= L_SEND;
          end
        end
        L_SEND: begin
          bit_reg <= bit_reg + 8'h01;
          if (in_crc) begin
            frame_reg <= {frame_reg[134:0], 1'b0};
          end else begin
            frame_reg <= {frame_reg[134:0], 1'b0};
          end
          if (bit_reg < len_reg - 8'(sdrf_pkg::CRC_START_BIT + 1) && bit_reg != 8'h00 ||
              bit_reg == 8'h00) begin
            // R2 CRC lies inside the register image; every frame accumulates, but only use_crc_reg frames send it
            crc_reg <= {crc_reg[5:0], 1'b0} ^ (crc_fb ? sdrf_pkg::CRC_POLY : 7'h00);
          end
          if (bit_reg == len_reg - 8'h01) begin
            if (busy_reg) begin
              lst_reg <= L_BUSY;
            end else begin
              rcvr_tgl_reg <= ~rcvr_tgl_reg;
              lst_reg <= L_IDLE;
            end
            if (hold_reg.kind == sdrf_pkg::SDRF_R6) begin
              addr_pub_reg <= 1'b1;
            end
          end
        end
        L_BUSY: begin
          if (!busy_sync_reg[1]) begin
            busy_reg <= 1'b0;
            rcvr_tgl_reg <= ~rcvr_tgl_reg;
            lst_reg <= L_IDLE;
          end
        end
        default: lst_reg <= L_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin drive, all on the rising link clock edge
  // ----------------------------------------------------------------
  always_ff @(posedge link_clk_i) begin
    if (lrst_reg) begin
      cmd_o <= 1'b1;
      cmd_oe_o <= 1'b0;
      dat0_o <= 1'b1;
      dat0_oe_o <= 1'b0;
    end else begin
      // Z bits undriven, P bits and frame driven
      cmd_oe_o <= (lst_reg == L_PULL) || (lst_reg == L_SEND && bit_reg < len_reg);
      if (lst_reg == L_SEND) begin
        cmd_o <= in_crc ? crc_reg[3'(crc_idx)] : frame_reg[135];
      end else begin
        cmd_o <= 1'b1;
      end
      // Busy on data line: after R1b, or between written blocks
      dat0_oe_o <= (lst_reg == L_BUSY) || busy_sync_reg[1];
      dat0_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_turn_undriven: assert property (@(posedge link_clk_i) disable iff (lrst_reg)
    (lst_reg == L_ARMED && cend_rise) |=> ##1 !cmd_oe_o ##1 !cmd_oe_o)
    else $error("command line driven during turnaround");
  a_pull_high: assert property (@(posedge link_clk_i) disable iff (lrst_reg)
    $past(lst_reg) == L_PULL |-> cmd_oe_o && cmd_o)
    else $error("pull-up bit not driven high");
  a_start_dir: assert property (@(posedge link_clk_i) disable iff (lrst_reg)
    (lst_reg == L_SEND && bit_reg == 8'h00) |=> !cmd_o ##1 !cmd_o)
    else $error("start or direction bit not zero");
  a_end_bit: assert property (@(posedge link_clk_i) disable iff (lrst_reg)
    (lst_reg == L_SEND && bit_reg == len_reg - 8'h01) |=> cmd_oe_o && cmd_o)
    else $error("end bit not one");
  a_no_r4r5: assert property (@(posedge link_clk_i) disable iff (lrst_reg)
    (lst_reg == L_IDLE && new_req && is_unsup) |=> lst_reg == L_IDLE)
    else $error("unsupported format started");
  a_len_short: assert property (@(posedge link_clk_i) disable iff (lrst_reg)
    (lst_reg == L_ARMED) |-> (len_reg == 8'h88) == (hold_reg.kind == sdrf_pkg::SDRF_R2))
    else $error("frame length wrong");
  a_id_delay: assert property (@(posedge link_clk_i) disable iff (lrst_reg)
    (lst_reg == L_ARMED && cend_rise && hold_reg.kind == sdrf_pkg::SDRF_R3)
    |=> wait_reg == ID_CNT)
    else $error("identification delay wrong");
  a_r3_ones: assert property (@(posedge link_clk_i) disable iff (lrst_reg)
    (lst_reg == L_SEND && !use_crc_reg && len_reg == 8'h30 && bit_reg > 8'h27 &&
     bit_reg < 8'h2F) |=> cmd_o)
    else $error("operating-conditions reserved bits not one");
  a_busy_low: assert property (@(posedge link_clk_i) disable iff (lrst_reg)
    (lst_reg == L_BUSY) |=> dat0_oe_o && !dat0_o)
    else $error("busy not shown on data line");

  c_short: cover property (@(posedge link_clk_i) lst_reg == L_SEND && len_reg == 8'h30);
  c_long: cover property (@(posedge link_clk_i) lst_reg == L_SEND && len_reg == 8'h88);
  c_busy: cover property (@(posedge link_clk_i) lst_reg == L_BUSY);
  c_pub: cover property (@(posedge link_clk_i) $rose(addr_pub_reg));

endmodule : sdrf_framer

`default_nettype wire

// file: verification/sdrf_host_model.sv
// Host side model: supplies the card clock, marks command ends, captures responses
`timescale 1ns/1ps
`default_nettype none

module sdrf_host_model #(
  parameter int RC_GAP = 8
) (
  input wire logic clk_en_i,
  input wire logic go_i,
  input wire logic cmd_oe_i,
  input wire logic cmd_line_i,
  input wire logic dat0_line_i,
  output logic link_clk_o,
  output logic cmd_end_o,
  output logic got_o,
  output logic [135:0] frame_o,
  output logic [8:0] z_cnt_o,
  output logic [8:0] p_cnt_o,
  output logic [8:0] n_bits_o
);
  logic busy;

  // ----------------------------------------------------------------
  // Card clock: stands still between transfers, odd offset to the core clock
  // ----------------------------------------------------------------
  initial begin
    link_clk_o = 1'h0;
    #1.3;
    forever begin
      #7.5;
      if (clk_en_i || busy || link_clk_o) link_clk_o = ~link_clk_o;
    end
  end

  // ----------------------------------------------------------------
  // One command end, then capture of the line until the card releases it
  // ----------------------------------------------------------------
  initial begin
    busy = 1'h0;
    cmd_end_o = 1'h0;
    got_o = 1'h0;
    frame_o = '0;
    z_cnt_o = '0;
    p_cnt_o = '0;
    n_bits_o = '0;
    forever begin
      wait (go_i === 1'h1);
      busy = 1'h1;
      z_cnt_o = '0;
      p_cnt_o = '0;
      n_bits_o = '0;
      frame_o = '0;
      repeat (3) @(posedge link_clk_o);
      cmd_end_o <= 1'h1;
      // Host never drives the line after its end bit, so Z reads as pull-up
      for (int i = 0; i < 300; i++) begin
        @(negedge link_clk_o);
        if (!cmd_oe_i) begin
          if (n_bits_o != 0) break;
          if (p_cnt_o == 0) z_cnt_o++;
        end else if (n_bits_o == 0 && cmd_line_i) begin
          p_cnt_o++;
        end else begin
          frame_o = {frame_o[134:0], cmd_line_i};
          n_bits_o++;
        end
      end
      while (dat0_line_i === 1'h0) @(posedge link_clk_o);
      repeat (RC_GAP) @(posedge link_clk_o);
      cmd_end_o <= 1'h0;
      got_o = 1'h1;
      wait (go_i === 1'h0);
      got_o = 1'h0;
      @(posedge link_clk_o);
      busy = 1'h0;
    end
  end
endmodule : sdrf_host_model

`default_nettype wire

// file: verification/sdrf_framer_bench.sv
// Self-checking bench for the card response framer
`timescale 1ns/1ps
`default_nettype none

module sdrf_framer_bench;
  localparam int ID_D = 5;
  localparam int CR_D = 3;
  localparam int GAP = 8;
  logic core_clk, rst, req_valid, wr_busy, clk_en, go, pub;
  sdrf_pkg::sdrf_req_s req;
  logic req_ready, done, addr_pub, cmd_o, cmd_oe, dat0_o, dat0_oe, link_clk, cmd_end, got;
  logic [135:0] frame;
  logic [8:0] z_cnt, p_cnt, n_bits;
  wire logic cmd_line = cmd_oe ? cmd_o : 1'h1;
  wire logic dat0_line = dat0_oe ? dat0_o : 1'h1;
  int mismatches, samples_checked, cycles, seed;
  sdrf_pkg::sdrf_kind_e seq [11] = '{sdrf_pkg::SDRF_R1, sdrf_pkg::SDRF_R2, sdrf_pkg::SDRF_R3,
    sdrf_pkg::SDRF_R4, sdrf_pkg::SDRF_R5, sdrf_pkg::SDRF_R1B, sdrf_pkg::SDRF_R6,
    sdrf_pkg::SDRF_R2, sdrf_pkg::SDRF_R3, sdrf_pkg::SDRF_R1, sdrf_pkg::SDRF_R1B};

  sdrf_framer #(.ID_DELAY(ID_D), .CR_DELAY(CR_D), .RC_GAP(GAP)) dut_u (
    .core_clk_i(core_clk), .rst_i(rst), .link_clk_i(link_clk), .req_valid_i(req_valid),
    .req_ready_o(req_ready), .req_i(req), .cmd_end_i(cmd_end), .wr_busy_i(wr_busy),
    .done_o(done), .addr_published_o(addr_pub), .cmd_i(cmd_line), .cmd_o(cmd_o),
    .cmd_oe_o(cmd_oe), .dat0_i(dat0_line), .dat0_o(dat0_o), .dat0_oe_o(dat0_oe));

  sdrf_host_model #(.RC_GAP(GAP)) host_u (
    .clk_en_i(clk_en), .go_i(go), .cmd_oe_i(cmd_oe), .cmd_line_i(cmd_line),
    .dat0_line_i(dat0_line), .link_clk_o(link_clk), .cmd_end_o(cmd_end), .got_o(got),
    .frame_o(frame), .z_cnt_o(z_cnt), .p_cnt_o(p_cnt), .n_bits_o(n_bits));

  // ----------------------------------------------------------------
  // Clock, watchdog, reporting
  // ----------------------------------------------------------------
  initial core_clk = 1'h0;
  always #2.5 core_clk = ~core_clk;

  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      close_out();
    end
  end

  task automatic chk(input logic [135:0] seen, input logic [135:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // ----------------------------------------------------------------
  // Expected frames
  // ----------------------------------------------------------------
  function automatic logic [6:0] crc7(input logic [39:0] d);
    logic [6:0] c;
    logic fb;
    c = 7'h00;
    for (int i = 39; i >= 0; i--) begin
      fb = d[i] ^ c[6];
      c = {c[5:0], 1'h0} ^ (fb ? 7'h09 : 7'h00);
    end
    return c;
  endfunction : crc7

  function automatic logic [135:0] frame_of(input sdrf_pkg::sdrf_req_s r);
    logic [39:0] h;
    case (r.kind)
      sdrf_pkg::SDRF_R2: return {2'h0, 6'h3F, r.reg_long[127:1], 1'h1};
      sdrf_pkg::SDRF_R3: return {88'h0, 2'h0, 6'h3F, r.status, 7'h7F, 1'h1};
      sdrf_pkg::SDRF_R4, sdrf_pkg::SDRF_R5: return '0;
      sdrf_pkg::SDRF_R6: h = {2'h0, 6'h03, r.new_addr, r.status[23], r.status[22],
        r.status[19], r.status[12:0]};
      default: h = {2'h0, r.cmd_index, r.status};
    endcase
    return {88'h0, h, crc7(h), 1'h1};
  endfunction : frame_of

  // ----------------------------------------------------------------
  // One request, one command end, one captured response
  // ----------------------------------------------------------------
  task automatic xfer(input sdrf_pkg::sdrf_kind_e k);
    sdrf_pkg::sdrf_req_s r;
    int pe;
    int len;
    logic none;
    r.kind = k;
    r.cmd_index = 6'($random(seed));
    r.status = $random(seed);
    r.reg_long = {$random(seed), $random(seed), $random(seed), $random(seed)};
    r.new_addr = 16'($random(seed));
    r.busy = (k == sdrf_pkg::SDRF_R1B);
    none = (k == sdrf_pkg::SDRF_R4 || k == sdrf_pkg::SDRF_R5);
    pe = (k == sdrf_pkg::SDRF_R3 || (k == sdrf_pkg::SDRF_R2 && !pub)) ? ID_D - 2 : CR_D - 2;
    len = none ? 0 : ((k == sdrf_pkg::SDRF_R2) ? 136 : 48);
    @(posedge core_clk);
    req_valid <= 1'h1;
    req <= r;
    wr_busy <= r.busy;
    @(posedge core_clk);
    for (int i = 0; i < 50 && req_ready !== 1'h1; i++) @(posedge core_clk);
    req_valid <= 1'h0;
    @(posedge core_clk);
    go <= 1'h1;
    chk(req_ready, 1'h0);
    // Busy of R1b holds completion back, so release it once the frame is out
    if (r.busy) begin
      repeat (400) @(posedge core_clk);
      chk({dat0_oe, dat0_line}, 2'h2);
      wr_busy <= 1'h0;
    end
    for (int i = 0; i < 5000 && done !== 1'h1; i++) @(posedge core_clk);
    chk(done, 1'h1);
    for (int i = 0; i < 5000 && got !== 1'h1; i++) @(posedge core_clk);
    chk(n_bits, 9'(len));
    chk(frame, frame_of(r));
    chk(p_cnt, none ? 9'h0 : 9'(pe));
    chk(z_cnt >= 2, 1'h1);
    if (k == sdrf_pkg::SDRF_R6) pub = 1'h1;
    chk(addr_pub, pub);
    go <= 1'h0;
    for (int i = 0; i < 500 && got !== 1'h0; i++) @(posedge core_clk);
  endtask : xfer

  task automatic do_reset;
    clk_en <= 1'h1;
    rst <= 1'h1;
    repeat (10) @(posedge core_clk);
    rst <= 1'h0;
    pub = 1'h0;
    repeat (20) @(posedge core_clk);
    clk_en <= 1'h0;
    chk({addr_pub, cmd_oe, dat0_oe}, 3'h0);
  endtask : do_reset

  // ----------------------------------------------------------------
  // Main sequence: every kind, random mix, idle write busy, reset mid-run
  // ----------------------------------------------------------------
  initial begin
    seed = 53544;
    mismatches = 0;
    samples_checked = 0;
    cycles = 0;
    rst = 1'h1;
    req_valid = 1'h0;
    req = '0;
    wr_busy = 1'h0;
    clk_en = 1'h1;
    go = 1'h0;
    pub = 1'h0;
    do_reset();
    foreach (seq[j]) xfer(seq[j]);
    for (int j = 0; j < 8; j++) xfer(sdrf_pkg::sdrf_kind_e'(3'($unsigned($random(seed)) % 5)));
    // Busy between written blocks needs no response on the command line
    clk_en <= 1'h1;
    wr_busy <= 1'h1;
    repeat (30) @(posedge core_clk);
    chk({dat0_oe, dat0_line}, 2'h2);
    wr_busy <= 1'h0;
    repeat (30) @(posedge core_clk);
    chk(dat0_oe, 1'h0);
    do_reset();
    xfer(sdrf_pkg::SDRF_R2);
    xfer(sdrf_pkg::SDRF_R6);
    close_out();
  end
endmodule : sdrf_framer_bench

`default_nettype wire
